// >>> adcc_analog_model.sv
`timescale 1ns/1ps
`default_nettype none

module adcc_analog_model (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic [3:0]  muxChannel,
    input  wire logic [1:0]  refSelect,
    input  wire logic        bandgapEnable,
    input  wire logic [11:0] sarCode,
    output logic             cmpHigh
);
    logic [11:0] level;
    logic        valid;

    always_comb begin
        level = {muxChannel, ~muxChannel, muxChannel ^ 4'h5};
        valid = (muxChannel != 4'hA) && !refSelect[1];
        if (muxChannel == 4'hB) begin
            valid = bandgapEnable && (refSelect == 2'h0);
        end
    end

    // an invalid setup toggles the comparator so a wrong result cannot pass by luck
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cmpHigh <= 1'b0;
        end else if (valid) begin
            cmpHigh <= (level >= sarCode);
        end else begin
            cmpHigh <= ~cmpHigh;
        end
    end
endmodule : adcc_analog_model

`default_nettype wire

// >>> adcc_clkdiv.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcc_map.svh"

module adcc_clkdiv
    import adcc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire logic [1:0] divSel,
    input  wire logic       restart,
    output logic            tick
);

    adcc_div_s div_r;
    adcc_div_s div_nxt;

    function automatic logic [4:0] lastCount(input logic [1:0] sel);
        case (sel)
            2'h0:    lastCount = `ADCC_DIV32_LAST;
            2'h1:    lastCount = `ADCC_DIV16_LAST;
            2'h2:    lastCount = `ADCC_DIV8_LAST;
            default: lastCount = `ADCC_DIV4_LAST;
        endcase
    endfunction : lastCount

    always_comb begin
        div_nxt = div_r;
        div_nxt.tick = 1'b0;
        if (restart) begin
            div_nxt.cnt = 5'h0;
        end else if (div_r.cnt >= lastCount(divSel)) begin
            // >= so a smaller divisor written mid-count still wraps
            div_nxt.cnt = 5'h0;
            div_nxt.tick = 1'b1;
        end else begin
            div_nxt.cnt = div_r.cnt + 5'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_r <= '0;
        end else begin
            div_r <= div_nxt;
        end
    end

    assign tick = div_r.tick;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    chk_tick_spacing: assert property (tick |=> !tick [*3])
        else $error("converter tick closer than four clocks");

endmodule : adcc_clkdiv

`default_nettype wire

// >>> adcc_map.svh
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH

// register indexes; byte address is four times the index
`define ADCC_IDX_PRESCALER  8'h94
`define ADCC_IDX_FLAG_BANK  8'h95
`define ADCC_IDX_RES_LOW    8'hAA
`define ADCC_IDX_RES_HIGH   8'hAB
`define ADCC_IDX_CHAN_REF   8'hAE
`define ADCC_IDX_AUX_CMD    8'hF8
`define ADCC_IDX_IRQ_STATUS 8'hC0
`define ADCC_IDX_IRQ_MASK   8'hC1

// field positions
`define ADCC_DIVSEL_LSB     2
`define ADCC_DONE_BIT       4
`define ADCC_START_BIT      4
`define ADCC_CHAN_LSB       4
`define ADCC_REF_LSB        2
`define ADCC_FORCEBG_BIT    1
`define ADCC_RESLO_LSB      4
`define ADCC_IRQ_DONE       0
`define ADCC_IRQ_ABORT      1

// reset values
`define ADCC_RST_DIVSEL     2'h0
`define ADCC_RST_CHAN       4'hF
`define ADCC_RST_REF        2'h0
`define ADCC_RST_FORCEBG    1'h0
`define ADCC_RST_MASK       2'h0

// codes
`define ADCC_CHAN_BANDGAP   4'hB
`define ADCC_REF_SUPPLY     2'h0

// divider terminal counts for /32, /16, /8, /4
`define ADCC_DIV32_LAST     5'h1F
`define ADCC_DIV16_LAST     5'h0F
`define ADCC_DIV8_LAST      5'h07
`define ADCC_DIV4_LAST      5'h03

// timing, in converter clock cycles; clock rates in Hz
`define ADCC_CONV_CYCLES    50
`define ADCC_BIT_CYCLES     2
`define ADCC_RES_BITS       12
`define ADCC_SAMPLE_CYCLES  (`ADCC_CONV_CYCLES - `ADCC_BIT_CYCLES * `ADCC_RES_BITS)
`define ADCC_SYSTEM_CLOCK_HZ      10000000
`define ADCC_CONV_MAX_HZ    1000000
`define ADCC_MIN_SAFE_DIV   ((`ADCC_SYSTEM_CLOCK_HZ + `ADCC_CONV_MAX_HZ - 1) / `ADCC_CONV_MAX_HZ)

`endif

// >>> adcc_pkg.sv
`default_nettype none

package adcc_pkg;

    typedef enum logic [2:0] {
        ADCC_IDLE    = 3'b001,
        ADCC_SAMPLE  = 3'b010,
        ADCC_CONVERT = 3'b100
    } adcc_state_e;

    typedef struct packed {
        adcc_state_e st;
        logic [1:0]  divSel;
        logic        doneFlag;
        logic [3:0]  chan;
        logic [1:0]  refSel;
        logic        forceBg;
        logic [7:0]  resHi;
        logic [3:0]  resLo;
        logic [11:0] trial;
        logic [3:0]  bitIdx;
        logic        phase;
        logic [4:0]  cnt;
        logic [1:0]  irqStat;
        logic [1:0]  irqMask;
        logic        waitReq;
        logic [31:0] rdata;
        logic        irq;
        logic        bandgapEn;
        logic        sampleHold;
        logic        busy;
        logic        doneEvt;
        logic        abortEvt;
    } adcc_regs_s;

    typedef struct packed {
        logic [4:0] cnt;
        logic       tick;
    } adcc_div_s;

endpackage : adcc_pkg

`default_nettype wire

// >>> adcc_top.sv
// Functional notes
// - writing 1 to the start bit begins a conversion and the bit reads 1 until the conversion ends.
// - writing 0 to the start bit clears it.
// - a finished conversion sets the done flag and, when enabled, raises the interrupt.
// - the done flag clears on a write of 0 to it or on a write of 1 to the start bit.
// - a conversion takes 50 converter clocks: sample-and-hold, then two clocks per result bit.
// - the result loads at completion, bits 11..4 to the high byte and bits 3..0 to the low byte's top nibble.
// - the 4-bit channel field drives the input multiplexer, code 1011 being the bandgap and 1111 quarter supply.
// - selecting the bandgap channel turns the bandgap generator on by itself.
// - the force bit keeps the bandgap on, idle mode included, but never in stop or halt mode.
// - the 2-bit reference field picks the supply (00) or the scaled bandgap (01).
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_map.svh"

module adcc_top
    import adcc_pkg::*;
#(
    parameter int RES_BITS      = `ADCC_RES_BITS,
    parameter int SAMPLE_CYCLES = `ADCC_SAMPLE_CYCLES
)
(
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        cmpHigh,
    input  wire logic        stopMode,
    output logic      [3:0]  muxChannel,
    output logic      [1:0]  refSelect,
    output logic             bandgapEnable,
    output logic             sampleHold,
    output logic      [11:0] sarCode,
    output logic             convBusy,
    output logic             irq
);

    if (RES_BITS != 12) begin : g_bad_width
        $error("result layout is fixed at 12 bits");
    end
    if (SAMPLE_CYCLES < 1 || SAMPLE_CYCLES > 31) begin : g_bad_sample
        $error("sample interval must be 1 to 31 converter clocks");
    end

    localparam logic [4:0] SAMPLE_LAST = 5'(SAMPLE_CYCLES - 1);

    adcc_regs_s  state_r;
    adcc_regs_s  state_nxt;

    logic [7:0]  regIdx;
    logic        wrLane;
    logic        startWr;
    logic        stopWr;
    logic        flagClrWr;
    logic        convStart;
    logic        tick;
    logic [11:0] finalCode;

    function automatic logic regHit(input logic [7:0] idx, input logic [7:0] target);
        regHit = (idx == target);
    endfunction : regHit

    assign regIdx    = avs_address[9:2];
    // write lands only at the edge where waitrequest is seen low
    assign wrLane    = avs_write && !state_r.waitReq && avs_byteenable[0];
    assign startWr   = wrLane && regHit(regIdx, `ADCC_IDX_AUX_CMD) && avs_writedata[`ADCC_START_BIT];
    assign stopWr    = wrLane && regHit(regIdx, `ADCC_IDX_AUX_CMD) && !avs_writedata[`ADCC_START_BIT];
    assign flagClrWr = wrLane && regHit(regIdx, `ADCC_IDX_FLAG_BANK) && !avs_writedata[`ADCC_DONE_BIT];
    assign convStart = startWr && (state_r.st == ADCC_IDLE);
    // last bit is decided by the comparator on the finishing tick
    assign finalCode = {state_r.trial[11:1], cmpHigh};

    adcc_clkdiv u_clkdiv (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .divSel  (state_r.divSel),
        .restart (convStart),
        .tick    (tick)
    );

    always_comb begin
        logic [7:0] rb;
        rb = 8'h00;
        state_nxt = state_r;
        state_nxt.doneEvt = 1'b0;
        state_nxt.abortEvt = 1'b0;

        // bus: one wait cycle, then a single low cycle that completes the access
        state_nxt.waitReq = 1'b1;
        if ((avs_read || avs_write) && state_r.waitReq) begin
            state_nxt.waitReq = 1'b0;
            if (regHit(regIdx, `ADCC_IDX_PRESCALER)) begin
                rb[`ADCC_DIVSEL_LSB +: 2] = state_r.divSel;
            end else if (regHit(regIdx, `ADCC_IDX_FLAG_BANK)) begin
                rb[`ADCC_DONE_BIT] = state_r.doneFlag;
            end else if (regHit(regIdx, `ADCC_IDX_RES_LOW)) begin
                rb[`ADCC_RESLO_LSB +: 4] = state_r.resLo;
            end else if (regHit(regIdx, `ADCC_IDX_RES_HIGH)) begin
                rb = state_r.resHi;
            end else if (regHit(regIdx, `ADCC_IDX_CHAN_REF)) begin
                rb[`ADCC_CHAN_LSB +: 4] = state_r.chan;
                rb[`ADCC_REF_LSB +: 2] = state_r.refSel;
                rb[`ADCC_FORCEBG_BIT] = state_r.forceBg;
            end else if (regHit(regIdx, `ADCC_IDX_AUX_CMD)) begin
                rb[`ADCC_START_BIT] = state_r.busy;
            end else if (regHit(regIdx, `ADCC_IDX_IRQ_STATUS)) begin
                rb[1:0] = state_r.irqStat;
            end else if (regHit(regIdx, `ADCC_IDX_IRQ_MASK)) begin
                rb[1:0] = state_r.irqMask;
            end
            if (avs_read) begin
                state_nxt.rdata = {24'h0000_00, rb};
            end
        end

        // configuration writes; result registers are read-only
        if (wrLane) begin
            if (regHit(regIdx, `ADCC_IDX_PRESCALER)) begin
                state_nxt.divSel = avs_writedata[`ADCC_DIVSEL_LSB +: 2];
            end else if (regHit(regIdx, `ADCC_IDX_CHAN_REF)) begin
                state_nxt.chan = avs_writedata[`ADCC_CHAN_LSB +: 4];
                state_nxt.refSel = avs_writedata[`ADCC_REF_LSB +: 2];
                state_nxt.forceBg = avs_writedata[`ADCC_FORCEBG_BIT];
            end else if (regHit(regIdx, `ADCC_IDX_IRQ_STATUS)) begin
                state_nxt.irqStat = state_r.irqStat & ~avs_writedata[1:0];
            end else if (regHit(regIdx, `ADCC_IDX_IRQ_MASK)) begin
                state_nxt.irqMask = avs_writedata[1:0];
            end
        end

        case (state_r.st)
            ADCC_IDLE: begin
                if (startWr) begin
                    state_nxt.st = ADCC_SAMPLE;
                    state_nxt.cnt = 5'h0;
                    state_nxt.trial = 12'h000;
                    state_nxt.sampleHold = 1'b1;
                end
            end
            ADCC_SAMPLE: begin
                if (stopWr) begin
                    state_nxt.st = ADCC_IDLE;
                    state_nxt.sampleHold = 1'b0;
                    state_nxt.abortEvt = 1'b1;
                end else if (tick) begin
                    if (state_r.cnt == SAMPLE_LAST) begin
                        state_nxt.st = ADCC_CONVERT;
                        state_nxt.bitIdx = 4'hB;
                        state_nxt.phase = 1'b0;
                        state_nxt.sampleHold = 1'b0;
                    end else begin
                        state_nxt.cnt = state_r.cnt + 5'h1;
                    end
                end
            end
            ADCC_CONVERT: begin
                if (stopWr) begin
                    state_nxt.st = ADCC_IDLE;
                    state_nxt.abortEvt = 1'b1;
                end else if (tick) begin
                    // two ticks a bit: set trial bit, then let the dac settle and judge
                    if (!state_r.phase) begin
                        state_nxt.trial[state_r.bitIdx] = 1'b1;
                        state_nxt.phase = 1'b1;
                    end else begin
                        state_nxt.phase = 1'b0;
                        if (!cmpHigh) begin
                            state_nxt.trial[state_r.bitIdx] = 1'b0;
                        end
                        if (state_r.bitIdx == 4'h0) begin
                            state_nxt.trial = finalCode;
                            state_nxt.resHi = finalCode[11:4];
                            state_nxt.resLo = finalCode[3:0];
                            state_nxt.st = ADCC_IDLE;
                            state_nxt.doneEvt = 1'b1;
                        end else begin
                            state_nxt.bitIdx = state_r.bitIdx - 4'h1;
                        end
                    end
                end
            end
            default: begin
                state_nxt.st = ADCC_IDLE;
                state_nxt.sampleHold = 1'b0;
            end
        endcase

        // set after clear so a completion in the clearing cycle survives
        if (flagClrWr || startWr) begin
            state_nxt.doneFlag = 1'b0;
        end
        if (state_nxt.doneEvt) begin
            state_nxt.doneFlag = 1'b1;
            state_nxt.irqStat[`ADCC_IRQ_DONE] = 1'b1;
        end
        if (state_nxt.abortEvt) begin
            state_nxt.irqStat[`ADCC_IRQ_ABORT] = 1'b1;
        end

        state_nxt.irq = |(state_nxt.irqStat & state_nxt.irqMask);
        state_nxt.busy = (state_nxt.st != ADCC_IDLE);
        // bandgap follows current settings; stop mode overrides the force bit
        state_nxt.bandgapEn = !stopMode
            && (state_r.forceBg || state_r.chan == `ADCC_CHAN_BANDGAP);
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= '0;
            state_r.st <= ADCC_IDLE;
            state_r.divSel <= `ADCC_RST_DIVSEL;
            state_r.chan <= `ADCC_RST_CHAN;
            state_r.refSel <= `ADCC_RST_REF;
            state_r.forceBg <= `ADCC_RST_FORCEBG;
            state_r.irqMask <= `ADCC_RST_MASK;
            state_r.waitReq <= 1'b1;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign avs_readdata    = state_r.rdata;
    assign avs_waitrequest = state_r.waitReq;
    assign muxChannel      = state_r.chan;
    assign refSelect       = state_r.refSel;
    assign bandgapEnable   = state_r.bandgapEn;
    assign sampleHold      = state_r.sampleHold;
    assign sarCode         = state_r.trial;
    assign convBusy        = state_r.busy;
    assign irq             = state_r.irq;

    // converter ticks seen while busy since the last start
    logic [5:0] convTicks;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            convTicks <= 6'h00;
        end else if (convStart) begin
            convTicks <= 6'h00;
        end else if (tick && state_r.busy) begin
            convTicks <= convTicks + 6'h01;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence s_launch;
        convStart;
    endsequence

    sequence s_running;
        state_r.busy && state_r.st != ADCC_IDLE;
    endsequence

    sequence s_finished;
        state_r.doneEvt && !state_r.busy;
    endsequence

    chk_start_busy: assert property (s_launch |=> s_running)
        else $error("start did not begin a conversion");

    chk_done_idle: assert property (state_r.doneEvt |-> s_finished)
        else $error("start bit still set after completion");

    chk_stop_clears: assert property (stopWr |=> !state_r.busy)
        else $error("writing zero did not clear the start bit");

    chk_done_sets: assert property (state_r.doneEvt |-> state_r.doneFlag && state_r.irqStat[0])
        else $error("completion did not set the done flag");

    chk_irq_gate: assert property (state_r.irqStat[0] && state_r.irqMask[0] |-> irq)
        else $error("unmasked done status without interrupt");

    chk_start_clears: assert property (startWr && !state_nxt.doneEvt |=> !state_r.doneFlag)
        else $error("start write left the done flag set");

    chk_conv_length: assert property (state_r.doneEvt |-> convTicks == 6'(`ADCC_CONV_CYCLES))
        else $error("conversion length is not fifty converter clocks");

    chk_result_layout: assert property (state_r.doneEvt |-> {state_r.resHi, state_r.resLo} == sarCode)
        else $error("result registers do not match the final code");

    chk_bandgap_auto: assert property (muxChannel == `ADCC_CHAN_BANDGAP && !stopMode |=> bandgapEnable)
        else $error("bandgap channel without bandgap enable");

    chk_bandgap_force: assert property (state_r.forceBg && !stopMode |=> bandgapEnable)
        else $error("forced bandgap not enabled");

    chk_bandgap_stop: assert property (stopMode |=> !bandgapEnable)
        else $error("bandgap enabled in stop mode");

    chk_abort_keeps: assert property (stopWr && state_r.busy
        |=> !state_r.doneEvt && $stable(state_r.resHi) && $stable(state_r.resLo))
        else $error("abort disturbed result or done flag");

endmodule : adcc_top

`default_nettype wire

// >>> tb_adcc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcc_map.svh"

module tb_adcc_top;
    logic        sys_clk;
    logic        rst_b;
    logic [9:0]  avsAddress;
    logic        avsRead;
    logic        avsWrite;
    logic [31:0] avsWriteData;
    logic [3:0]  avsByteEnable;
    logic [31:0] avsReadData;
    logic        avsWaitReq;
    logic        cmpHigh;
    logic        stopMode;
    logic [3:0]  muxChannel;
    logic [1:0]  refSelect;
    logic        bandgapEnable;
    logic        sampleHold;
    logic [11:0] sarCode;
    logic        convBusy;
    logic        irq;
    logic [3:0]  beSel;
    int          failCount;
    int          nCompared;
    int          cyc = 0;

    adcc_top u_adcc_top (
        .sys_clk        (sys_clk),
        .rst_b          (rst_b),
        .avs_address    (avsAddress),
        .avs_read       (avsRead),
        .avs_write      (avsWrite),
        .avs_writedata  (avsWriteData),
        .avs_byteenable (avsByteEnable),
        .avs_readdata   (avsReadData),
        .avs_waitrequest(avsWaitReq),
        .cmpHigh        (cmpHigh),
        .stopMode       (stopMode),
        .muxChannel     (muxChannel),
        .refSelect      (refSelect),
        .bandgapEnable  (bandgapEnable),
        .sampleHold     (sampleHold),
        .sarCode        (sarCode),
        .convBusy       (convBusy),
        .irq            (irq)
    );

    adcc_analog_model u_adcc_analog_model (
        .sys_clk      (sys_clk),
        .rst_b        (rst_b),
        .muxChannel   (muxChannel),
        .refSelect    (refSelect),
        .bandgapEnable(bandgapEnable),
        .sarCode      (sarCode),
        .cmpHigh      (cmpHigh)
    );

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) cyc <= cyc + 1;

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        nCompared++;
        if (got !== exp) begin
            failCount++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic endOfTest();
        if (failCount == 0 && nCompared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : endOfTest

    // request held until waitrequest is sampled low, then released
    task automatic busAccess(input logic wr, input logic [7:0] idx, input logic [7:0] d, output logic [31:0] q);
        int n;
        @(posedge sys_clk);
        avsAddress    <= {idx, 2'b00};
        avsWriteData  <= {24'h00_0000, d};
        avsByteEnable <= beSel;
        avsWrite      <= wr;
        avsRead       <= !wr;
        n = 0;
        @(posedge sys_clk);
        // no limit here: only the watchdog ends a wait that never finishes
        while (avsWaitReq !== 1'b0) begin
            @(posedge sys_clk);
            n++;
        end
        // the slave promises exactly one wait state per access
        check("wait states", 32'h0000_0001, n);
        q = avsReadData;
        avsWrite <= 1'b0;
        avsRead  <= 1'b0;
    endtask : busAccess

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] q;
        busAccess(1'b1, idx, d, q);
    endtask : wr

    task automatic rdChk(input string what, input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] q;
        busAccess(1'b0, idx, 8'h00, q);
        check(what, {24'h00_0000, exp}, q);
    endtask : rdChk

    task automatic settle(input string what, input logic exp, input bit ofIrq);
        repeat (2) @(negedge sys_clk);
        // sampled after the wait: bandgapEnable lags its cause by a clock, irq changes on the same edge as the status register
        if (ofIrq) check(what, {31'h0, exp}, {31'h0, irq});
        else check(what, {31'h0, exp}, {31'h0, bandgapEnable});
    endtask : settle

    function automatic logic [11:0] lvl(input logic [3:0] c);
        return {c, ~c, c ^ 4'h5};
    endfunction : lvl

    // no touch-key channels exist in this bench, any channel except 1010 (invalid in the model) is free to convert
    task automatic runConv(input logic [1:0] div, input logic [3:0] ch, input bit abortIt);
        int          s;
        int          lim;
        logic [11:0] e;
        wr(`ADCC_IDX_PRESCALER, {4'h0, div, 2'b00});
        wr(`ADCC_IDX_CHAN_REF, {ch, 4'h0});
        wr(`ADCC_IDX_AUX_CMD, 8'h10);
        s = cyc;
        @(negedge sys_clk);
        check("sample hold", 32'h0000_0001, {31'h0, sampleHold});
        check("busy", 32'h0000_0001, {31'h0, convBusy});
        rdChk("done flag after start", `ADCC_IDX_FLAG_BANK, 8'h00);
        rdChk("start bit busy", `ADCC_IDX_AUX_CMD, 8'h10);
        if (abortIt) begin
            wr(`ADCC_IDX_AUX_CMD, 8'h00);
            rdChk("start bit cleared", `ADCC_IDX_AUX_CMD, 8'h00);
            return;
        end
        lim = `ADCC_CONV_CYCLES * (32 >> div);
        while (1) begin
            @(posedge sys_clk);
            if (convBusy === 1'b0 || cyc - s > lim + 8) break;
        end
        // busy drops one clock after the fiftieth tick period and is seen low one edge later
        check("conversion cycles", lim + 2, cyc - s);
        check("irq at done", 32'h0000_0001, {31'h0, irq});
        rdChk("done flag", `ADCC_IDX_FLAG_BANK, 8'h10);
        rdChk("start bit idle", `ADCC_IDX_AUX_CMD, 8'h00);
        e = lvl(ch);
        check("final code", {20'h0, e}, {20'h0, sarCode});
        rdChk("result high", `ADCC_IDX_RES_HIGH, e[11:4]);
        rdChk("result low", `ADCC_IDX_RES_LOW, {e[3:0], 4'h0});
    endtask : runConv

    initial begin
        logic [1:0] r;
        logic [11:0] eAbort;
        rst_b = 1'b0;
        avsAddress = 10'h000;
        avsRead = 1'b0;
        avsWrite = 1'b0;
        avsWriteData = 32'h0000_0000;
        avsByteEnable = 4'hF;
        beSel = 4'hF;
        stopMode = 1'b0;
        failCount = 0;
        nCompared = 0;
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'b1;
        rdChk("chan ref reset", `ADCC_IDX_CHAN_REF, 8'hF0);
        rdChk("prescaler reset", `ADCC_IDX_PRESCALER, 8'h00);
        rdChk("flag reset", `ADCC_IDX_FLAG_BANK, 8'h00);
        rdChk("aux reset", `ADCC_IDX_AUX_CMD, 8'h00);
        rdChk("mask reset", `ADCC_IDX_IRQ_MASK, 8'h00);
        rdChk("unmapped", 8'h10, 8'h00);
        wr(`ADCC_IDX_PRESCALER, 8'h08);
        rdChk("prescaler div8", `ADCC_IDX_PRESCALER, 8'h08);
        wr(`ADCC_IDX_PRESCALER, 8'h0C);
        rdChk("prescaler div4", `ADCC_IDX_PRESCALER, 8'h0C);
        for (int i = 0; i < 16; i++) begin
            r = (i == 11) ? 2'b00 : i[1:0];
            wr(`ADCC_IDX_CHAN_REF, {i[3:0], r, 2'b00});
            settle("bandgap auto", i == 11, 1'b0);
            check("mux channel", {28'h0, i[3:0]}, {28'h0, muxChannel});
            check("reference", {30'h0, r}, {30'h0, refSelect});
            rdChk("chan ref", `ADCC_IDX_CHAN_REF, {i[3:0], r, 2'b00});
        end
        wr(`ADCC_IDX_CHAN_REF, 8'h02);
        settle("bandgap forced", 1'b1, 1'b0);
        @(posedge sys_clk) stopMode <= 1'b1;
        settle("bandgap in stop", 1'b0, 1'b0);
        @(posedge sys_clk) stopMode <= 1'b0;
        beSel = 4'h0;
        wr(`ADCC_IDX_CHAN_REF, 8'h50);
        beSel = 4'hF;
        rdChk("byte enable off", `ADCC_IDX_CHAN_REF, 8'h02);
        wr(`ADCC_IDX_IRQ_MASK, 8'h01);
        for (int d = 0; d < 4; d++) begin
            // codes 10 and 11 give over 1 MHz at this system clock, so they are only read back
            runConv({1'b0, d[0]}, {d[1:0], 2'b01}, 1'b0);
            if (d == 0) begin
                wr(`ADCC_IDX_FLAG_BANK, 8'hFF);
                rdChk("flag after write one", `ADCC_IDX_FLAG_BANK, 8'h10);
            end
            if (!d[0]) begin
                wr(`ADCC_IDX_FLAG_BANK, 8'hEF);
                rdChk("flag cleared", `ADCC_IDX_FLAG_BANK, 8'h00);
            end
            wr(`ADCC_IDX_IRQ_STATUS, 8'h01);
            settle("irq cleared", 1'b0, 1'b1);
        end
        runConv(2'b00, 4'h3, 1'b1);
        check("busy after abort", 32'h0000_0000, {31'h0, convBusy});
        check("hold after abort", 32'h0000_0000, {31'h0, sampleHold});
        repeat (1700) @(posedge sys_clk);
        eAbort = lvl(4'hD);
        rdChk("flag after abort", `ADCC_IDX_FLAG_BANK, 8'h00);
        rdChk("high after abort", `ADCC_IDX_RES_HIGH, eAbort[11:4]);
        rdChk("low after abort", `ADCC_IDX_RES_LOW, {eAbort[3:0], 4'h0});
        rdChk("abort status", `ADCC_IDX_IRQ_STATUS, 8'h02);
        check("irq masked", 32'h0000_0000, {31'h0, irq});
        wr(`ADCC_IDX_IRQ_MASK, 8'h02);
        settle("irq unmasked", 1'b1, 1'b1);
        wr(`ADCC_IDX_IRQ_STATUS, 8'h02);
        settle("irq after clear", 1'b0, 1'b1);
        endOfTest();
    end

    initial begin
        repeat (12000) @(posedge sys_clk);
        check("watchdog", 32'h0000_0000, 32'h0000_0001);
        endOfTest();
    end
endmodule : tb_adcc_top

`default_nettype wire
